//--- verilog/cogen_top.sv
// complementary output generator core: event sync, timers, mode mapping.
// assumes rise_src and fall_src may be asynchronous; all config on clk.
`timescale 1ns/1ps
`default_nettype none
`include "cogen_map.svh"

// Notes on behaviour
// [R1] mode 000 is steered, 001 synchronous steered
// [R2] mode 010 is forward full-bridge, 011 reverse full-bridge
// [R3] mode 100 is half-bridge with primary and complementary waveforms
// [R4] mode 101 is push-pull
// [R5] steered modes put the pwm on any outputs picked by steering
// [R6] plain steered: steering write takes effect on the next cycle
// [R7] synchronous steered: new steering waits for the next rising event
// [R8] static data on unsteered outputs updates at once in either mode
// [R9] period follows rising events, duty spans rising to falling event
// [R10] events may be asynchronous and may share one source
// [R11] full-bridge: two outputs active, one modulated, one held on
// [R12] direction change delays modulated output by a dead-band time
// [R13] forward: output d modulated, output a held on
// [R14] reverse: output b modulated, output c held on
// [R15] half-bridge turn-on delayed after the other turns off
// [R16] half-bridge primary on a and c, complementary on b and d
// [R17] push-pull: a equals c, b equals d
// [R18] push-pull drive runs from rising to falling event
// [R19] push-pull each rising event swaps to the other output pair
// [R20] optional blanking of opposite event input after each event
// [R21] optional phase delay between event and drive
// [R22] dead-band from generator clock or a clock-independent chain; the chain option here counts every clk
// [R23] while disabled primary inactive and complementary active
// [R24] rising event: phase, clear complementary, blank, dead-band, set primary
module cogen_top
   import cogen_pkg::*;
#(
   parameter int                      TW      = `COGEN_TMR_W,
   parameter logic [`COGEN_DIV_W-1:0] GEN_DIV = `COGEN_GEN_DIV
)
(
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          enable_i,
   input  wire logic [2:0]    operating_mode_field,
   input  wire logic [3:0]    steer_in,
   input  wire logic          steer_wr,
   input  wire logic [3:0]    static_data,
   input  wire logic          rise_src,
   input  wire logic          fall_src,
   input  wire logic [TW-1:0] phase_rise_len,
   input  wire logic [TW-1:0] phase_fall_len,
   input  wire logic [TW-1:0] blank_rise_len,
   input  wire logic [TW-1:0] blank_fall_len,
   input  wire logic [TW-1:0] db_rise_len,
   input  wire logic [TW-1:0] db_fall_len,
   input  wire logic          db_rise_chain,
   input  wire logic          db_fall_chain,
   output logic               drive_out_a,
   output logic               drive_out_b,
   output logic               drive_out_c,
   output logic               drive_out_d
);

   cogen_state_s q;
   cogen_state_s d;
   cogen_mode_e  md;
   cogen_mode_e  md_prev;

   logic [TW-1:0]            t_load [`COGEN_T_NUM];
   logic [`COGEN_T_NUM-1:0]  t_raw;
   logic [`COGEN_T_NUM-1:0]  t_start;
   logic [`COGEN_T_NUM-1:0]  t_fire;
   logic [`COGEN_T_NUM-1:0]  t_busy;
   logic [`COGEN_T_NUM-1:0]  t_done;
   logic [`COGEN_T_NUM-1:0]  t_tick;
   logic                     rise_edge;
   logic                     fall_edge;
   logic                     rise_ev;
   logic                     fall_ev;
   logic                     half;
   logic                     to_fwd;
   logic                     to_rev;
   logic                     fb_mask;

   // zero length means the stage is skipped
   function automatic logic is_zero(input logic [TW-1:0] v);
      is_zero = (v == '0);
   endfunction

   assign md      = cogen_mode_e'(operating_mode_field);
   assign md_prev = cogen_mode_e'(q.mode_prev);
   assign half    = (md == COGEN_HALF); // R3

   // ===================================================================
   // event detection after the synchronisers
   // level counts once second and third stage agree
   assign rise_edge = (q.rs[1] == q.rs[2]) && q.rs[2] && !q.rise_lvl; // R10
   assign fall_edge = (q.fs[1] == q.fs[2]) && !q.fs[2] && q.fall_lvl; // R10
   // blanking hides the opposite input after each event
   assign rise_ev   = enable_i && rise_edge && !t_busy[`COGEN_T_BL_R]; // R20
   assign fall_ev   = enable_i && fall_edge && !t_busy[`COGEN_T_BL_F]; // R20

   // ===================================================================
   // timer sequencing
   assign t_load[`COGEN_T_PH_R] = phase_rise_len;
   assign t_load[`COGEN_T_PH_F] = phase_fall_len;
   assign t_load[`COGEN_T_BL_R] = blank_rise_len;
   assign t_load[`COGEN_T_BL_F] = blank_fall_len;
   assign t_load[`COGEN_T_DB_R] = db_rise_len;
   assign t_load[`COGEN_T_DB_F] = db_fall_len;

   // direction change in full-bridge
   assign to_fwd = enable_i && md == COGEN_FWD && md_prev == COGEN_REV;
   assign to_rev = enable_i && md == COGEN_REV && md_prev == COGEN_FWD;

   // phase stages start on the events
   assign t_raw[`COGEN_T_PH_R]  = rise_ev; // R21 R24
   assign t_raw[`COGEN_T_PH_F]  = fall_ev; // R21
   assign t_fire[`COGEN_T_PH_R] = (t_raw[`COGEN_T_PH_R] && is_zero(phase_rise_len)) || t_done[`COGEN_T_PH_R];
   assign t_fire[`COGEN_T_PH_F] = (t_raw[`COGEN_T_PH_F] && is_zero(phase_fall_len)) || t_done[`COGEN_T_PH_F];
   // blanking and half-bridge dead-band start once phase delay is over
   assign t_raw[`COGEN_T_BL_F]  = t_fire[`COGEN_T_PH_R]; // R24
   assign t_raw[`COGEN_T_BL_R]  = t_fire[`COGEN_T_PH_F]; // R20
   assign t_raw[`COGEN_T_DB_R]  = (half && t_fire[`COGEN_T_PH_R]) || to_fwd; // R15 R12
   assign t_raw[`COGEN_T_DB_F]  = (half && t_fire[`COGEN_T_PH_F]) || to_rev; // R15 R12
   assign t_fire[`COGEN_T_BL_R] = t_done[`COGEN_T_BL_R];
   assign t_fire[`COGEN_T_BL_F] = t_done[`COGEN_T_BL_F];
   assign t_fire[`COGEN_T_DB_R] = (t_raw[`COGEN_T_DB_R] && is_zero(db_rise_len)) || t_done[`COGEN_T_DB_R];
   assign t_fire[`COGEN_T_DB_F] = (t_raw[`COGEN_T_DB_F] && is_zero(db_fall_len)) || t_done[`COGEN_T_DB_F];

   // modulated output held off while direction dead-band runs
   assign fb_mask = t_busy[`COGEN_T_DB_R] || t_busy[`COGEN_T_DB_F] || to_fwd || to_rev; // R12

   // timer bank; chain dead-band counts every clk, not the timing clock
   genvar k;
   generate
      for (k = 0; k < `COGEN_T_NUM; k++)
      begin : g_tmr
         assign t_start[k] = t_raw[k] && !is_zero(t_load[k]);
         assign t_tick[k]  = ((k == `COGEN_T_DB_R) && db_rise_chain)
                          || ((k == `COGEN_T_DB_F) && db_fall_chain) || q.tick; // R22
         cogen_timer #(.W(TW)) u_tmr
         (
            .clk   (clk),
            .rst_n (rst_n),
            .start (t_start[k]),
            .tick  (t_tick[k]),
            .load  (t_load[k]),
            .busy  (t_busy[k]),
            .done  (t_done[k])
         );
      end
   endgenerate

   // ===================================================================
   // next state
   always_comb
   begin
      d = q;
      // three-stage synchronisers
      d.rs = {q.rs[1:0], rise_src};
      d.fs = {q.fs[1:0], fall_src};
      if (q.rs[1] == q.rs[2])
         d.rise_lvl = q.rs[2];
      if (q.fs[1] == q.fs[2])
         d.fall_lvl = q.fs[2];
      d.mode_prev = operating_mode_field;
      // generator timing clock enable
      if (q.div >= GEN_DIV - 1'b1)
      begin
         d.div  = '0;
         d.tick = 1'b1;
      end
      else
      begin
         d.div  = q.div + 1'b1;
         d.tick = 1'b0;
      end
      // half-bridge dead-band expiry; a zero length expires with its event
      // the event branches below come later so that a new event wins
      if (half && t_fire[`COGEN_T_DB_R] && (q.rise_act || t_fire[`COGEN_T_PH_R]))
         d.prim = 1'b1; // R15 R24
      if (half && t_fire[`COGEN_T_DB_F] && (q.fall_act || t_fire[`COGEN_T_PH_F]))
         d.comp = 1'b1; // R15
      // rising side: clear complementary; set primary now, in half-bridge after dead-band
      if (t_fire[`COGEN_T_PH_R])
      begin
         d.rise_act = 1'b1;
         d.fall_act = 1'b0;
         d.comp     = 1'b0; // R24
         if (!half)
            d.prim = 1'b1; // R9 R18
      end
      // falling side: clear primary; set complementary now, in half-bridge after dead-band
      if (t_fire[`COGEN_T_PH_F])
      begin
         d.fall_act = 1'b1;
         d.rise_act = 1'b0;
         d.prim     = 1'b0; // R9 R18
         if (!half)
            d.comp = 1'b1;
      end
      // push-pull pair alternates per period
      if (rise_ev)
         d.pp_sel = !q.pp_sel; // R19
      // steering register
      if (steer_wr && md == COGEN_SYNC)
      begin
         d.steer_pend = steer_in; // R7
         d.pend       = 1'b1;
      end
      else if (steer_wr)
         d.steer = steer_in; // R6
      if (md == COGEN_SYNC && q.pend && rise_ev)
      begin
         d.steer = q.steer_pend; // R7
         d.pend  = steer_wr;
      end
      else if (md != COGEN_SYNC && q.pend)
      begin
         // a write in this same cycle is newer than the pending value
         if (!steer_wr)
            d.steer = q.steer_pend;
         d.pend = 1'b0;
      end
      // disabled: primary off, complementary on
      if (!enable_i)
      begin
         d.prim     = 1'b0; // R23
         d.comp     = 1'b1; // R23
         d.rise_act = 1'b0;
         d.fall_act = 1'b0;
         d.pp_sel   = 1'b1;
      end
      // output mapping per mode; bit 0 is a, bit 3 is d
      unique case (md)
         COGEN_STEER, COGEN_SYNC:
            for (int i = 0; i < 4; i++)
               d.outs[i] = q.steer[i] ? q.prim : static_data[i]; // R1 R5 R8
         COGEN_FWD:
            d.outs = {q.prim && !fb_mask, 1'b0, 1'b0, enable_i}; // R2 R11 R13
         COGEN_REV:
            d.outs = {1'b0, enable_i, q.prim && !fb_mask, 1'b0}; // R2 R11 R14
         COGEN_HALF:
            d.outs = {q.comp, q.prim, q.comp, q.prim}; // R3 R16
         COGEN_PUSH:
            d.outs = {q.prim && q.pp_sel, q.prim && !q.pp_sel,
                      q.prim && q.pp_sel, q.prim && !q.pp_sel}; // R4 R17 R18
         default:
            d.outs = 4'h0;
      endcase
   end

   // state register
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         q        <= '0;
         q.steer  <= `COGEN_STEER_RST;
         q.comp   <= 1'b1;
         q.pp_sel <= 1'b1;
      end
      else
         q <= d;
   end

   assign drive_out_a = q.outs[0];
   assign drive_out_b = q.outs[1];
   assign drive_out_c = q.outs[2];
   assign drive_out_d = q.outs[3];

   // ===================================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence fwd_held_s;
      (enable_i && md == COGEN_FWD)[*2];
   endsequence

   sequence rev_held_s;
      (enable_i && md == COGEN_REV)[*2];
   endsequence

   fwd_map_a: assert property (fwd_held_s |-> q.outs[0] && !q.outs[1] && !q.outs[2]) // R13
      else $error("forward mode mapping wrong");
   rev_map_a: assert property (rev_held_s |-> q.outs[2] && !q.outs[0] && !q.outs[3]) // R14
      else $error("reverse mode mapping wrong");
   dir_mask_a: assert property (t_busy[`COGEN_T_DB_R] && md == COGEN_FWD ##1 md == COGEN_FWD
                                |-> !q.outs[3]) // R12
      else $error("modulated output not held in dead-band");
   rev_mask_a: assert property (t_busy[`COGEN_T_DB_F] && md == COGEN_REV ##1 md == COGEN_REV
                                |-> !q.outs[1]) // R12
      else $error("reverse modulated output not held in dead-band");
   half_pair_a: assert property ((md == COGEN_HALF)[*2] |-> q.outs[0] == q.outs[2]
                                 && q.outs[1] == q.outs[3]) // R16
      else $error("half-bridge pairs differ");
   push_pair_a: assert property ((md == COGEN_PUSH)[*2] |-> q.outs[0] == q.outs[2]
                                 && q.outs[1] == q.outs[3] && !(q.outs[0] && q.outs[1])) // R17
      else $error("push-pull pairs wrong");
   push_swap_a: assert property (rise_ev && enable_i |=> q.pp_sel != $past(q.pp_sel)) // R19
      else $error("push-pull pair did not swap");
   off_state_a: assert property (!enable_i ##1 !enable_i |-> !q.prim && q.comp) // R23
      else $error("disabled output state wrong");
   steer_now_a: assert property (steer_wr && md == COGEN_STEER |=> q.steer == $past(steer_in)) // R6
      else $error("steering not applied next cycle");
   steer_hold_a: assert property (md == COGEN_SYNC && !rise_ev |=> q.steer == $past(q.steer)) // R7
      else $error("sync steering changed without event");
   comp_clear_a: assert property (enable_i && t_fire[`COGEN_T_PH_R] ##1 enable_i |-> !q.comp) // R24
      else $error("complementary not cleared");
   static_a: assert property ((md == COGEN_STEER && !q.steer[0])[*2] |-> q.outs[0] == $past(static_data[0])) // R8
      else $error("static data not passed");

endmodule

`default_nettype wire

//--- verilog/cogen_map.svh
// constants of the complementary output generator: mode codes, timer slots,
// reset values and timing counts.
// assumes inclusion by its bare name from the package and the design files.
`ifndef COGEN_MAP_SVH
`define COGEN_MAP_SVH

// ======================================================================
// operating mode field codes
`define COGEN_MD_STEER 3'h0
`define COGEN_MD_SYNC  3'h1
`define COGEN_MD_FWD   3'h2
`define COGEN_MD_REV   3'h3
`define COGEN_MD_HALF  3'h4
`define COGEN_MD_PUSH  3'h5

// ======================================================================
// timer slots
`define COGEN_T_PH_R   0
`define COGEN_T_PH_F   1
`define COGEN_T_BL_R   2
`define COGEN_T_BL_F   3
`define COGEN_T_DB_R   4
`define COGEN_T_DB_F   5
`define COGEN_T_NUM    6

// ======================================================================
// widths, reset values and timing counts
`define COGEN_TMR_W     8
`define COGEN_DIV_W     8
`define COGEN_GEN_DIV   8'h01
`define COGEN_STEER_RST 4'h0

`endif

//--- verilog/cogen_pkg.sv
// types of the complementary output generator.
// assumes cogen_map.svh is on the include path.
`include "cogen_map.svh"

package cogen_pkg;

   // ===================================================================
   // operating modes
   typedef enum logic [2:0]
   {
      COGEN_STEER = `COGEN_MD_STEER,
      COGEN_SYNC  = `COGEN_MD_SYNC,
      COGEN_FWD   = `COGEN_MD_FWD,
      COGEN_REV   = `COGEN_MD_REV,
      COGEN_HALF  = `COGEN_MD_HALF,
      COGEN_PUSH  = `COGEN_MD_PUSH
   } cogen_mode_e;

   // ===================================================================
   // state of the generator core
   typedef struct packed
   {
      logic [2:0]              rs;
      logic [2:0]              fs;
      logic                    rise_lvl;
      logic                    fall_lvl;
      logic [3:0]              steer;
      logic [3:0]              steer_pend;
      logic                    pend;
      logic                    rise_act;
      logic                    fall_act;
      logic                    prim;
      logic                    comp;
      logic                    pp_sel;
      logic [2:0]              mode_prev;
      logic [`COGEN_DIV_W-1:0] div;
      logic                    tick;
      logic [3:0]              outs;
   } cogen_state_s;

endpackage

//--- verilog/cogen_timer.sv
// one-shot down counter used for phase delay, blanking and dead-band.
// assumes start and tick come from logic on clk.
`timescale 1ns/1ps
`default_nettype none
`include "cogen_map.svh"

module cogen_timer
   import cogen_pkg::*;
#(
   parameter int W = `COGEN_TMR_W
)
(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         start,
   input  wire logic         tick,
   input  wire logic [W-1:0] load,
   output logic              busy,
   output logic              done
);

   typedef struct packed
   {
      logic [W-1:0] cnt;
      logic         busy;
      logic         done;
   } cogen_tmr_s;

   cogen_tmr_s q;
   cogen_tmr_s d;

   // ===================================================================
   // count down on tick, pulse done when the count runs out
   always_comb
   begin
      d      = q;
      d.done = 1'b0;
      if (start)
      begin
         d.busy = 1'b1;
         d.cnt  = load;
      end
      else if (q.busy && q.cnt == '0)
      begin
         d.busy = 1'b0;
         d.done = 1'b1;
      end
      else if (q.busy && tick)
      begin
         d.cnt = q.cnt - 1'b1;
      end
   end

   // state register
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         q <= '0;
      else
         q <= d;
   end

   assign busy = q.busy;
   assign done = q.done;

endmodule

`default_nettype wire

//--- test/cogen_driver_model.sv
// power switch driver stage model: watches the four drive levels.
// assumes legs a/b and c/d, active high drive, same clock as the bench.
`timescale 1ns/1ps
`default_nettype none

module cogen_driver_model
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic clr,
   input  wire logic drv_a,
   input  wire logic drv_b,
   input  wire logic drv_c,
   input  wire logic drv_d,
   output logic      overlap_q
);
   // ===================================================================
   // sticky shoot-through flag
   // both switches of one leg on means a short across the supply
   always_ff @(posedge clk)
   begin
      if (!rst_n || clr)
         overlap_q <= 1'b0;
      else if ((drv_a && drv_b) || (drv_c && drv_d))
         overlap_q <= 1'b1;
   end
endmodule

`default_nettype wire

//--- test/cogen_top_bench.sv
// bench of cogen_top: one task per scenario, outputs polled with bounds.
// assumes cogen_pkg, cogen_map.svh and cogen_driver_model compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "cogen_map.svh"

module cogen_top_bench;
   import cogen_pkg::*;

   logic       clk;
   logic       rst_n;
   logic       en;
   logic       wr;
   logic       rs;
   logic       fs;
   logic       clr;
   logic [2:0] md;
   logic [3:0] sin;
   logic [3:0] sd;
   logic [7:0] prl;
   logic [7:0] pfl;
   logic [7:0] brl;
   logic [7:0] bfl;
   logic [7:0] drl;
   logic [7:0] dfl;
   logic       drc;
   logic       dfc;
   wire logic  a;
   wire logic  b;
   wire logic  c;
   wire logic  d;
   wire logic  ovl;
   int         error_cnt;
   int         comparisons;

   // ===================================================================
   // design and far side
   cogen_top uut (.clk(clk), .rst_n(rst_n), .enable_i(en), .operating_mode_field(md), .steer_in(sin),
      .steer_wr(wr), .static_data(sd), .rise_src(rs), .fall_src(fs), .phase_rise_len(prl),
      .phase_fall_len(pfl), .blank_rise_len(brl), .blank_fall_len(bfl), .db_rise_len(drl),
      .db_fall_len(dfl), .db_rise_chain(drc), .db_fall_chain(dfc), .drive_out_a(a), .drive_out_b(b),
      .drive_out_c(c), .drive_out_d(d));
   cogen_driver_model drv (.clk(clk), .rst_n(rst_n), .clr(clr), .drv_a(a), .drv_b(b), .drv_c(c),
      .drv_d(d), .overlap_q(ovl));

   // ===================================================================
   // clock
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // ===================================================================
   // helpers
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #10;
   endtask

   task automatic chk(input logic [3:0] exp);
      comparisons++;
      if ({d, c, b, a} !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: outputs %b, expected %b", $time, {d, c, b, a}, exp);
      end
   endtask

   task automatic chk_flag(input logic got, input logic exp);
      comparisons++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: flag %b, expected %b", $time, got, exp);
      end
   endtask

   // waits up to n cycles for the outputs, then compares
   task automatic wt(input logic [3:0] exp, input int n);
      int i;
      i = 0;
      while ({d, c, b, a} !== exp && i < n)
      begin
         cyc(1);
         i++;
      end
      chk(exp);
   endtask

   task automatic pwm(input logic v);
      rs = v;
      fs = v;
   endtask

   task automatic steer(input logic [3:0] v);
      sin = v;
      wr = 1'b1;
      cyc(1);
      wr = 1'b0;
   endtask

   // ===================================================================
   // scenarios
   task automatic t_steer();
      md = `COGEN_MD_STEER;
      sd = 4'hA;
      en = 1'b1;
      cyc(8);
      chk(4'hA);
      steer(4'h3);
      pwm(1'b1);
      wt(4'hB, 10);
      pwm(1'b0);
      wt(4'h8, 10);
      sd = 4'h0;
      pwm(1'b1);
      cyc(8);
      steer(4'h5);
      cyc(2);
      chk(4'h5);
      $display("steered test done");
   endtask

   task automatic t_sync();
      md = `COGEN_MD_SYNC;
      pwm(1'b0);
      cyc(8);
      steer(4'hA);
      cyc(4);
      chk(4'h0);
      sd = 4'hA;
      wt(4'hA, 3);
      sd = 4'h0;
      cyc(3);
      chk(4'h0);
      pwm(1'b1);
      wt(4'hA, 10);
      $display("synchronous steered test done");
   endtask

   task automatic t_fb();
      clr = 1'b1;
      cyc(1);
      clr = 1'b0;
      md = `COGEN_MD_FWD;
      wt(4'h9, 10);
      pwm(1'b0);
      wt(4'h1, 10);
      dfl = 8'h0C;
      md = `COGEN_MD_REV;
      pwm(1'b1);
      cyc(6);
      chk(4'h4);
      wt(4'h6, 30);
      pwm(1'b0);
      wt(4'h4, 10);
      dfl = 8'h00;
      drl = 8'h0C;
      md = `COGEN_MD_FWD;
      pwm(1'b1);
      cyc(6);
      chk(4'h1);
      wt(4'h9, 30);
      pwm(1'b0);
      wt(4'h1, 10);
      drl = 8'h00;
      chk_flag(ovl, 1'b0);
      $display("full-bridge test done");
   endtask

   task automatic t_half();
      int gap;
      gap = 0;
      md = `COGEN_MD_HALF;
      drl = 8'h04;
      dfl = 8'h04;
      wt(4'hA, 20);
      pwm(1'b1);
      while ({d, c, b, a} !== 4'h5 && gap < 40)
      begin
         cyc(1);
         if ({d, c, b, a} === 4'h0)
            gap++;
      end
      chk(4'h5);
      chk_flag(gap >= 3, 1'b1);
      pwm(1'b0);
      wt(4'hA, 30);
      chk_flag(ovl, 1'b0);
      $display("half-bridge test done");
   endtask

   task automatic t_dis();
      pwm(1'b1);
      wt(4'h5, 30);
      en = 1'b0;
      wt(4'hA, 10);
      pwm(1'b0);
      cyc(8);
      en = 1'b1;
      cyc(2);
      chk(4'hA);
      drl = 8'h00;
      dfl = 8'h00;
      pwm(1'b1);
      wt(4'h5, 10);
      pwm(1'b0);
      wt(4'hA, 10);
      $display("enable test done");
   endtask

   task automatic t_push();
      md = `COGEN_MD_PUSH;
      en = 1'b0;
      cyc(2);
      en = 1'b1;
      cyc(2);
      pwm(1'b1);
      wt(4'h5, 10);
      pwm(1'b0);
      wt(4'h0, 10);
      pwm(1'b1);
      wt(4'hA, 10);
      pwm(1'b0);
      wt(4'h0, 10);
      pwm(1'b1);
      wt(4'h5, 10);
      pwm(1'b0);
      wt(4'h0, 10);
      chk_flag(ovl, 1'b0);
      $display("push-pull test done");
   endtask

   task automatic t_timers();
      md = `COGEN_MD_FWD;
      wt(4'h1, 10);
      bfl = 8'h14;
      pwm(1'b1);
      cyc(4);
      pwm(1'b0);
      cyc(12);
      chk(4'h9);
      bfl = 8'h00;
      cyc(20);
      pwm(1'b1);
      cyc(4);
      pwm(1'b0);
      wt(4'h1, 20);
      prl = 8'h0F;
      pwm(1'b1);
      cyc(8);
      chk(4'h1);
      wt(4'h9, 30);
      prl = 8'h00;
      pwm(1'b0);
      wt(4'h1, 20);
      $display("blanking and phase test done");
   endtask

   // ===================================================================
   // verdict
   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ===================================================================
   // watchdog, far beyond the expected run
   initial
   begin
      #(5000 * 100);
      error_cnt++;
      $display("Error at %0t: watchdog expired", $time);
      tally_and_finish();
   end

   // ===================================================================
   // main sequence
   initial
   begin
      error_cnt = 0;
      comparisons = 0;
      rst_n = 1'b0;
      en = 1'b0;
      wr = 1'b0;
      clr = 1'b0;
      md = `COGEN_MD_STEER;
      sin = 4'h0;
      sd = 4'h0;
      pwm(1'b0);
      prl = 8'h00;
      pfl = 8'h00;
      brl = 8'h00;
      bfl = 8'h00;
      drl = 8'h00;
      dfl = 8'h00;
      drc = 1'b0;
      dfc = 1'b1;
      cyc(8);
      chk(4'h0);
      rst_n = 1'b1;
      t_steer();
      t_sync();
      t_fb();
      t_half();
      t_dis();
      t_push();
      t_timers();
      tally_and_finish();
   end
endmodule

`default_nettype wire
